// *** design/ddr_core_pkg.sv ***
// Shared constants, carriers and enumerations for the DDR access core.
// Assumes a 200 MHz system clock that oversamples every device pin.
package ddr_core_pkg;

   // ==========================================================
   // Organisation
   localparam int WORD_W = 16;
   localparam int BYTE_W = 8;
   localparam int LANES = 2;
   localparam int BANKS = 4;
   localparam int BANK_W = 2;
   localparam int ROW_W = 2;
   localparam int COL_W = 4;
   localparam int ADDR_W = 13;
   localparam int IDX_W = BANK_W + ROW_W + COL_W;
   localparam int MEM_DEPTH = 1 << IDX_W;
   localparam int AUTO_PRECHARGE_SELECT_BIT = 10;

   // ==========================================================
   // Mode register fields and reset values
   localparam int MR_BL_LSB = 0;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam int EMR_PARTIAL_ARRAY_SELF_REFRESH_LSB = 0;
   localparam logic [1:0] MR_SEL_STD = 2'h0;
   localparam logic [1:0] MR_SEL_EXT = 2'h2;
   localparam logic [2:0] MR_BL_RST = 3'h3;
   localparam logic [2:0] MR_CL_RST = 3'h3;
   localparam logic [2:0] EMR_PARTIAL_ARRAY_SELF_REFRESH_RST = 3'h0;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int TRP_NS = 15;
   localparam int TRP_CYCLES = (TRP_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int TREFI_NS = 7800;
   localparam int TREFI_CYCLES = TREFI_NS * 1000 / CLK_PERIOD_PS;

   // ==========================================================
   // Register map
   localparam logic [7:0] TEMP_CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] REFRESH_COUNT_OFS = 8'h08;
   localparam int TEMP_W = 2;
   localparam logic [TEMP_W-1:0] TEMP_RST = 2'h0;

   // ==========================================================
   // Carriers and enumerations
   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic bank_select_bit1;
      logic bank_select_bit0;
      logic [ADDR_W-1:0] addr;
   } cmd_pins_s;

   typedef struct packed {
      logic hsel;
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic hready;
   } ahb_req_s;

   typedef enum logic [1:0] {
      P_ACTIVE = 2'h0, P_PD = 2'h1, P_SREF = 2'h3, P_DPD = 2'h2
   } pwr_e;

   typedef enum logic [1:0] {
      D_IDLE = 2'h0, D_RD_WAIT = 2'h1, D_RD = 2'h3, D_WR = 2'h2
   } dat_e;

   typedef enum logic [1:0] {
      B_IDLE = 2'h0, B_OPEN = 2'h1, B_PRE = 2'h3
   } bank_e;

   typedef struct packed {
      logic [13:0] zero;
      logic [2:0] partial_array_self_refresh;
      logic interleave;
      logic [2:0] bl_code;
      logic [2:0] cl;
      dat_e dat;
      pwr_e pwr;
      logic [BANKS-1:0] open;
   } status_s;

endpackage : ddr_core_pkg

// *** design/data_byte_lane.sv ***
// One byte lane: synchronises its strobe, data byte and byte mask.
// Assumes write data is centred on the strobe edges by the controller.
`timescale 1ns/1ps
module data_byte_lane
   import ddr_core_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Lane pins
   input wire logic strobe_in,
   input wire logic [BYTE_W-1:0] data_in,
   input wire logic mask_in,
   // Captured beat
   output logic beat_pulse,
   output logic [BYTE_W-1:0] beat_data,
   output logic beat_mask
);

   typedef struct packed {
      logic st1;
      logic st2;
      logic st3;
      logic [BYTE_W-1:0] d1;
      logic [BYTE_W-1:0] d2;
      logic m1;
      logic m2;
      logic pulse;
      logic [BYTE_W-1:0] data_q;
      logic mask_q;
   } lane_s;

   lane_s s;
   lane_s n;

   // ==========================================================
   // Capture on either strobe edge
   always_comb begin
      n = s;
      n.st1 = strobe_in;
      n.st2 = s.st1;
      n.st3 = s.st2;
      n.d1 = data_in;
      n.d2 = s.d1;
      n.m1 = mask_in;
      n.m2 = s.m1;
      n.pulse = s.st2 ^ s.st3;
      if (s.st2 ^ s.st3) begin
         n.data_q = s.d2;
         n.mask_q = s.m2;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign beat_pulse = s.pulse;
   assign beat_data = s.data_q;
   assign beat_mask = s.mask_q;

endmodule : data_byte_lane

// *** design/bank_row_tracker.sv ***
// One bank: open row and the self-timed precharge of that bank.
// Assumes open and close requests arrive as one-cycle pulses.
`timescale 1ns/1ps
module bank_row_tracker
   import ddr_core_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Requests
   input wire logic open_req,
   input wire logic [ROW_W-1:0] row_in,
   input wire logic close_req,
   // State
   output logic is_open,
   output logic [ROW_W-1:0] open_row
);

   typedef struct packed {
      bank_e st;
      logic [ROW_W-1:0] row;
      logic [1:0] timer;
   } bank_s;

   bank_s s;
   bank_s n;

   // ==========================================================
   // Row state
   always_comb begin
      n = s;
      unique case (s.st)
         B_IDLE: begin
            if (open_req) begin
               n.st = B_OPEN;
               n.row = row_in;
            end
         end
         B_OPEN: begin
            if (close_req) begin
               n.st = B_PRE;
               n.timer = 2'(TRP_CYCLES - 1);
            end
         end
         B_PRE: begin
            if (s.timer == 2'h0) begin
               n.st = B_IDLE;
            end else begin
               n.timer = s.timer - 2'h1;
            end
         end
         default: n.st = B_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign is_open = (s.st == B_OPEN);
   assign open_row = s.row;

   // ==========================================================
   // Checks
   trp_wait_a: assert property (
      @(posedge clk) disable iff (!rst_n)
      (close_req && s.st == B_OPEN) |=>
         (s.st == B_PRE) [*3] ##1 (s.st == B_IDLE))
      else $error("Precharge did not finish in time.");

endmodule : bank_row_tracker

// *** design/ddr_sdram_access_core.sv ***
// Device-side core of a double-data-rate DRAM with four banks.
// Assumes pins reach it asynchronously and are oversampled by clk,
// and that a bus master reaches its status over AHB-Lite.
`timescale 1ns/1ps

module ddr_sdram_access_core
   import ddr_core_pkg::*;
#(
   parameter int REFI_CYCLES = TREFI_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Clock and command pins
   input wire logic true_clock_input,
   input wire logic complement_clock_input,
   input wire cmd_pins_s cmd_pins,
   // Data pins
   input wire logic [WORD_W-1:0] dq_in,
   output logic [WORD_W-1:0] dq_out,
   output logic dq_oe,
   input wire logic [LANES-1:0] dqs_in,
   output logic [LANES-1:0] dqs_out,
   output logic dqs_oe,
   input wire logic [LANES-1:0] write_byte_mask,
   // AHB-Lite slave
   input wire ahb_req_s ahb_req,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);

   typedef struct packed {
      logic ck_s1;
      logic ck_s2;
      logic ck_s3;
      logic ckn_s1;
      logic ckn_s2;
      cmd_pins_s cmd_s1;
      cmd_pins_s cmd_s2;
      logic [2:0] mr_bl_code;
      logic mr_interleave;
      logic [2:0] mr_cl;
      logic [2:0] emr_partial_array_self_refresh;
      pwr_e pwr;
      dat_e dat;
      logic [1:0] lat;
      logic [4:0] beat;
      logic [COL_W-1:0] start_col;
      logic [BANK_W-1:0] bank;
      logic ap;
      logic [WORD_W-1:0] pair;
      logic [WORD_W-1:0] wr_lo;
      logic [LANES-1:0] wr_lo_mask;
      logic [MEM_DEPTH-1:0][WORD_W-1:0] mem;
      logic [WORD_W-1:0] dq_out;
      logic dq_oe;
      logic dqs_out;
      logic dqs_oe;
      logic [15:0] sref_cnt;
      logic [15:0] ref_cnt;
      logic [BANK_W-1:0] ref_bank;
      logic [TEMP_W-1:0] temp;
      logic wr_pend;
      logic [7:0] wr_ofs;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } core_s;

   core_s s;
   core_s n;

   // ==========================================================
   // Helpers
   function automatic logic [COL_W-1:0] burst_col(
      input logic [COL_W-1:0] start, input logic [4:0] i,
      input logic [4:0] bl, input logic ilv);
      logic [COL_W-1:0] m;
      logic [COL_W-1:0] o;
      m = COL_W'(bl - 5'h01);
      o = ilv ? (start ^ i[COL_W-1:0]) : (start + i[COL_W-1:0]);
      burst_col = (start & ~m) | (o & m);
   endfunction : burst_col

   function automatic logic partial_array_self_refresh_on(input logic [2:0] partial_array_self_refresh,
      input logic [BANK_W-1:0] b);
      unique case (partial_array_self_refresh)
         3'h1: partial_array_self_refresh_on = (b < 2'h2);
         3'h2: partial_array_self_refresh_on = (b == 2'h0);
         default: partial_array_self_refresh_on = 1'b1;
      endcase
   endfunction : partial_array_self_refresh_on

   cmd_pins_s c;
   logic rise;
   logic fall;
   logic sel;
   logic [BANK_W-1:0] ba;
   logic cmd_act, cmd_rd, cmd_wr, cmd_bst, cmd_pre, cmd_ref, cmd_lmr;
   logic [4:0] bl;
   logic [15:0] interval;
   logic [BANKS-1:0] act_v;
   logic [BANKS-1:0] pre_v;
   logic [BANKS-1:0] bank_open;
   logic [BANKS-1:0][ROW_W-1:0] bank_row;
   logic [LANES-1:0] lane_pulse;
   logic [LANES-1:0] lane_mask;
   logic [WORD_W-1:0] lane_word;
   logic [IDX_W-1:0] rd_idx_lo, rd_idx_hi, wr_idx_lo, wr_idx_hi;
   logic ahb_addr;
   logic emit;
   status_s status;

   assign c = s.cmd_s2;
   assign rise = s.ck_s2 & ~s.ck_s3 & ~s.ckn_s2;
   assign fall = ~s.ck_s2 & s.ck_s3;
   assign sel = c.cke & ~c.cs_n & (s.pwr == P_ACTIVE);
   assign ba = {c.bank_select_bit1, c.bank_select_bit0};
   assign cmd_act = sel & ~c.ras_n & c.cas_n & c.we_n;
   assign cmd_rd = sel & c.ras_n & ~c.cas_n & c.we_n;
   assign cmd_wr = sel & c.ras_n & ~c.cas_n & ~c.we_n;
   assign cmd_bst = sel & c.ras_n & c.cas_n & ~c.we_n;
   assign cmd_pre = sel & ~c.ras_n & c.cas_n & ~c.we_n;
   assign cmd_ref = sel & ~c.ras_n & ~c.cas_n & c.we_n;
   assign cmd_lmr = sel & ~c.ras_n & ~c.cas_n & ~c.we_n;
   assign bl = (s.mr_bl_code == 3'h1) ? 5'h02 :
      (s.mr_bl_code == 3'h2) ? 5'h04 :
      (s.mr_bl_code == 3'h4) ? 5'h10 : 5'h08;
   assign interval = 16'(REFI_CYCLES * (4 - int'(s.temp)));
   assign rd_idx_lo = {s.bank, bank_row[s.bank],
      burst_col(s.start_col, s.beat, bl, s.mr_interleave)};
   assign rd_idx_hi = {s.bank, bank_row[s.bank],
      burst_col(s.start_col, s.beat + 5'h01, bl, s.mr_interleave)};
   assign wr_idx_lo = {s.bank, bank_row[s.bank],
      burst_col(s.start_col, s.beat - 5'h01, bl, s.mr_interleave)};
   assign wr_idx_hi = rd_idx_lo;
   assign ahb_addr = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[1];
   assign emit = (s.dat == D_RD_WAIT && s.lat == 2'h1) ||
      (s.dat == D_RD && s.beat != bl);
   assign status = '{zero: '0, partial_array_self_refresh: s.emr_partial_array_self_refresh,
      interleave: s.mr_interleave, bl_code: s.mr_bl_code,
      cl: s.mr_cl, dat: s.dat, pwr: s.pwr, open: bank_open};

   // ==========================================================
   // Banks and byte lanes
   // Each bank keeps its own row state, so one may open or close
   // while another streams burst data.
   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      bank_row_tracker u_bank (
         .clk(clk),
         .rst_n(rst_n),
         .open_req(act_v[b]),
         .row_in(c.addr[ROW_W-1:0]),
         .close_req(pre_v[b]),
         .is_open(bank_open[b]),
         .open_row(bank_row[b])
      );
   end

   for (genvar l = 0; l < LANES; l++) begin : g_lane
      data_byte_lane u_lane (
         .clk(clk),
         .rst_n(rst_n),
         .strobe_in(dqs_in[l]),
         .data_in(dq_in[l*BYTE_W +: BYTE_W]),
         .mask_in(write_byte_mask[l]),
         .beat_pulse(lane_pulse[l]),
         .beat_data(lane_word[l*BYTE_W +: BYTE_W]),
         .beat_mask(lane_mask[l])
      );
   end

   // ==========================================================
   // Next state
   always_comb begin
      n = s;
      act_v = '0;
      pre_v = '0;
      n.ck_s1 = true_clock_input;
      n.ck_s2 = s.ck_s1;
      n.ck_s3 = s.ck_s2;
      n.ckn_s1 = complement_clock_input;
      n.ckn_s2 = s.ckn_s1;
      n.cmd_s1 = cmd_pins;
      n.cmd_s2 = s.cmd_s1;
      // Read strobe and data change together on both clock edges;
      // there is no loop to shift them, only the oversampling delay.
      if (fall && s.dat == D_RD_WAIT && s.lat == 2'h1) begin
         n.dqs_oe = 1'b1;
         n.dqs_out = 1'b0;
      end
      if (fall && s.dat == D_RD) begin
         n.dq_out = s.pair;
         n.dqs_out = 1'b0;
      end
      if (rise && emit) begin
         n.dat = D_RD;
         n.dq_out = s.mem[rd_idx_lo];
         n.pair = s.mem[rd_idx_hi];
         n.dq_oe = 1'b1;
         n.dqs_oe = 1'b1;
         n.dqs_out = 1'b1;
         n.beat = s.beat + 5'h02;
      end else if (rise && s.dat == D_RD_WAIT) begin
         n.lat = s.lat - 2'h1;
      end else if (rise && s.dat == D_RD) begin
         n.dat = D_IDLE;
         n.dq_oe = 1'b0;
         n.dqs_oe = 1'b0;
         pre_v[s.bank] = s.ap;
      end
      if (s.dat == D_WR && lane_pulse[0]) begin
         // Lanes are assumed to strobe within the same sample.
         if (!s.beat[0]) begin
            n.wr_lo = lane_word;
            n.wr_lo_mask = lane_mask;
         end else begin
            for (int l = 0; l < LANES; l++) begin
               if (!s.wr_lo_mask[l]) begin
                  n.mem[wr_idx_lo][l*BYTE_W +: BYTE_W] =
                     s.wr_lo[l*BYTE_W +: BYTE_W];
               end
               if (!lane_mask[l]) begin
                  n.mem[wr_idx_hi][l*BYTE_W +: BYTE_W] =
                     lane_word[l*BYTE_W +: BYTE_W];
               end
            end
         end
         n.beat = s.beat + 5'h01;
         if (s.beat + 5'h01 == bl) begin
            n.dat = D_IDLE;
            pre_v[s.bank] = s.ap;
         end
      end
      if (rise) begin
         if (cmd_act) begin
            act_v[ba] = 1'b1;
         end
         if (cmd_pre) begin
            if (c.addr[AUTO_PRECHARGE_SELECT_BIT]) begin
               pre_v = '1;
            end else begin
               pre_v[ba] = 1'b1;
            end
         end
         if (cmd_rd || cmd_wr) begin
            n.dat = cmd_rd ? D_RD_WAIT : D_WR;
            n.lat = (s.mr_cl == 3'h3) ? 2'h2 : 2'h1;
            n.beat = '0;
            n.start_col = c.addr[COL_W-1:0];
            n.bank = ba;
            n.ap = c.addr[AUTO_PRECHARGE_SELECT_BIT];
            n.dq_oe = 1'b0;
            n.dqs_oe = 1'b0;
         end
         if (cmd_bst && !s.ap && s.dat != D_WR) begin
            n.dat = D_IDLE;
            n.dq_oe = 1'b0;
            n.dqs_oe = 1'b0;
         end
         if (cmd_ref) begin
            n.ref_cnt = s.ref_cnt + 16'h0001;
         end
         if (cmd_lmr && ba == MR_SEL_STD) begin
            n.mr_bl_code = c.addr[MR_BL_LSB +: 3];
            n.mr_interleave = c.addr[MR_BT_BIT];
            n.mr_cl = c.addr[MR_CL_LSB +: 3];
         end
         if (cmd_lmr && ba == MR_SEL_EXT) begin
            n.emr_partial_array_self_refresh = c.addr[EMR_PARTIAL_ARRAY_SELF_REFRESH_LSB +: 3];
         end
         if (s.pwr == P_ACTIVE && !c.cke && !c.cs_n) begin
            if (~c.ras_n & ~c.cas_n & c.we_n) begin
               n.pwr = P_SREF;
            end else if (c.ras_n & c.cas_n & ~c.we_n) begin
               n.pwr = P_DPD;
               n.mem = '0;
               pre_v = '1;
               n.dat = D_IDLE;
               n.dq_oe = 1'b0;
               n.dqs_oe = 1'b0;
            end else begin
               n.pwr = P_PD;
            end
         end else if (s.pwr == P_ACTIVE && !c.cke) begin
            n.pwr = P_PD;
         end else if (s.pwr == P_PD && c.cke) begin
            n.pwr = P_ACTIVE;
         end
      end
      // Self refresh and deep power-down leave on the level of the
      // enable alone, since the clock may be stopped there.
      if ((s.pwr == P_SREF || s.pwr == P_DPD) && c.cke) begin
         n.pwr = P_ACTIVE;
      end
      if (s.pwr == P_SREF) begin
         if (s.sref_cnt >= interval - 16'h0001) begin
            n.sref_cnt = '0;
            n.ref_bank = s.ref_bank + 2'h1;
            if (partial_array_self_refresh_on(s.emr_partial_array_self_refresh, s.ref_bank)) begin
               n.ref_cnt = s.ref_cnt + 16'h0001;
            end
         end else begin
            n.sref_cnt = s.sref_cnt + 16'h0001;
         end
      end else begin
         n.sref_cnt = '0;
      end
      n.wr_pend = ahb_addr & ahb_req.hwrite;
      n.wr_ofs = ahb_req.haddr[7:0];
      if (s.wr_pend && s.wr_ofs == TEMP_CTRL_OFS) begin
         n.temp = hwdata[TEMP_W-1:0];
      end
      if (ahb_addr && !ahb_req.hwrite) begin
         unique case (ahb_req.haddr[7:0])
            TEMP_CTRL_OFS: n.hrdata = {30'h0, s.temp};
            STATUS_OFS: n.hrdata = status;
            REFRESH_COUNT_OFS: n.hrdata = {16'h0, s.ref_cnt};
            default: n.hrdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.mr_bl_code <= MR_BL_RST;
         s.mr_cl <= MR_CL_RST;
         s.emr_partial_array_self_refresh <= EMR_PARTIAL_ARRAY_SELF_REFRESH_RST;
         s.temp <= TEMP_RST;
         s.hreadyout <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign dq_out = s.dq_out;
   assign dq_oe = s.dq_oe;
   assign dqs_out = {LANES{s.dqs_out}};
   assign dqs_oe = s.dqs_oe;
   assign hrdata = s.hrdata;
   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   rd_strobe_a: assert property (
      s.dq_oe |-> s.dqs_oe)
      else $error("Read data driven without its strobe.");

   edge_align_a: assert property (
      (s.dq_oe && $past(s.dq_oe) && s.dq_out != $past(s.dq_out))
      |-> (s.dqs_out != $past(s.dqs_out)))
      else $error("Read data moved without a strobe edge.");

   first_data_a: assert property (
      (rise && s.dat == D_RD_WAIT && s.lat == 2'h1) |=>
         (s.dq_oe && s.dqs_out && s.dat == D_RD))
      else $error("First read word late.");

   fall_half_a: assert property (
      (fall && s.dat == D_RD) |=> (s.dq_out == $past(s.pair)))
      else $error("Second half of prefetch not shown.");

   burst_end_a: assert property (
      (rise && s.dat == D_RD && s.beat == bl) |=>
         (!s.dq_oe && !s.dqs_oe && s.dat == D_IDLE))
      else $error("Read burst ran past its length.");

   act_open_a: assert property (
      (rise && cmd_act && !bank_open[ba]) |=> ##1 bank_open[$past(ba, 2)])
      else $error("Activate did not open its bank.");

   auto_close_a: assert property (
      (rise && s.dat == D_RD && s.beat == bl && s.ap &&
         bank_open[s.bank]) |=> ##1 !bank_open[$past(s.bank, 2)])
      else $error("Auto precharge did not close the row.");

   dpd_clear_a: assert property (
      (s.pwr != P_DPD) ##1 (s.pwr == P_DPD) |-> (s.mem == '0))
      else $error("Array kept data into deep power-down.");

   sref_rate_a: assert property (
      (s.pwr == P_SREF) |-> (s.sref_cnt < interval))
      else $error("Self refresh interval overrun.");

endmodule : ddr_sdram_access_core

// *** verification/ddr_ctrl_model.sv ***
// Controller model: link clock, command pins, write strobes and data.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps
module ddr_ctrl_model
   import ddr_core_pkg::*;
(
   // Device outputs
   input wire logic [WORD_W-1:0] dq_out,
   input wire logic dq_oe,
   input wire logic [LANES-1:0] dqs_out,
   input wire logic dqs_oe,
   // Device inputs
   output logic true_clock_input,
   output logic complement_clock_input,
   output cmd_pins_s cmd_pins,
   output logic [WORD_W-1:0] dq_in,
   output logic [LANES-1:0] dqs_in,
   output logic [LANES-1:0] write_byte_mask
);
   logic [WORD_W-1:0] dq_d;
   logic [LANES-1:0] dqs_d;
   // A released data bus shows the inverse of its last level.
   assign dq_in = dq_oe ? dq_out : dq_d;
   assign dqs_in = dqs_oe ? dqs_out : dqs_d;
   assign complement_clock_input = ~true_clock_input;
   initial begin
      true_clock_input = 1'b0;
      cmd_pins = {1'b1, 4'hf, 15'h0};
      dq_d = '0;
      dqs_d = '0;
      write_byte_mask = '0;
   end
   // ====
   // One link period; the rise is kept off the system clock grid.
   task automatic tick(input logic [4:0] op, input logic [14:0] a);
      cmd_pins = {op, a};
      #41.3 true_clock_input = 1'b1;
      #38.7 true_clock_input = 1'b0;
   endtask : tick
   // Self refresh: the enable stays low and the link clock stops.
   task automatic sref(input int ns);
      cmd_pins = {5'h01, 15'h0};
      #41.3 true_clock_input = 1'b1;
      #38.7 true_clock_input = 1'b0;
      #(ns) cmd_pins = {1'b1, 4'h7, 15'h0};
   endtask : sref
   // Data settles a quarter period before each strobe edge.
   task automatic wbeats(input int n, input logic [17:0] b [16]);
      fork
         repeat (n / 2 + 1) tick(5'h17, 15'h0);
         for (int j = 0; j < n; j++) begin
            #21.3 {write_byte_mask, dq_d} = b[j];
            #18.7 dqs_d = ~dqs_d;
         end
      join
      dq_d = ~dq_d;
   endtask : wbeats
endmodule : ddr_ctrl_model

// *** verification/tb_ddr_sdram_access_core.sv ***
// Bench: status over AHB-Lite, bursts through the controller model.
// Assumes the self-refresh tick base is shortened to 20.
`timescale 1ns/1ps
module tb_ddr_sdram_access_core
   import ddr_core_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic true_clock_input, complement_clock_input, dq_oe, dqs_oe;
   cmd_pins_s cmd_pins;
   ahb_req_s ahb_req;
   logic [WORD_W-1:0] dq_in, dq_out;
   logic [LANES-1:0] dqs_in, dqs_out, write_byte_mask;
   logic [31:0] h_addr = '0, hwdata = '0, hrdata, e;
   logic [1:0] h_trans = 2'h0;
   logic h_write = 1'b0, hreadyout, hresp, rd_ph = 1'b0, s_prev, oe_prev;
   logic [31:0] aq[$];
   logic [15:0] dq_q[$], mem[MEM_DEPTH];
   int fails = 0, n_compared = 0, cyc = 0;
   assign ahb_req = {1'b1, h_trans, h_addr, h_write, 3'h2, hreadyout};
   always #2.5 clk = ~clk;
   ddr_sdram_access_core #(.REFI_CYCLES(20)) dut_u (
      .clk, .rst_n, .true_clock_input, .complement_clock_input, .cmd_pins,
      .dq_in, .dq_out, .dq_oe, .dqs_in, .dqs_out, .dqs_oe,
      .write_byte_mask, .ahb_req, .hwdata, .hrdata, .hreadyout, .hresp);
   ddr_ctrl_model ctl_u (
      .dq_out, .dq_oe, .dqs_out, .dqs_oe, .true_clock_input,
      .complement_clock_input, .cmd_pins, .dq_in, .dqs_in,
      .write_byte_mask);
   // ====
   task automatic check(input string nm, input logic [31:0] s, x);
      n_compared++;
      if (s !== x) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask : check
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic bus(input logic w, input logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      h_trans <= 2'h2;
      h_addr <= {24'h0, a};
      h_write <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      h_trans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask : bus
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      aq.push_back(x);
      bus(1'b0, a, 32'h0);
   endtask : rd
   function automatic logic [31:0] st(logic [3:0] o, logic [2:0] l, b);
      return {18'h0, b, l, 4'h0, o};
   endfunction : st
   // ====
   // Monitor: each result takes the oldest note off its queue.
   always @(posedge clk) begin
      if (rd_ph && hreadyout === 1'b1) begin
         e = aq.size() ? aq.pop_front() : 'x;
         check("hrdata", hrdata, e);
         check("hresp", {31'h0, hresp}, 32'h0);
      end
      if (hreadyout === 1'b1) rd_ph <= h_trans[1] & ~h_write;
      if (dq_oe === 1'b1 && (dqs_out[0] !== s_prev || oe_prev !== 1'b1)) begin
         check("strobe", {dqs_oe, dqs_out[1]}, {1'b1, dqs_out[0]});
         e = dq_q.size() ? dq_q.pop_front() : 'x;
         check("dq", dq_out, e);
      end
      s_prev <= dqs_out[0];
      oe_prev <= dq_oe;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         test_done;
      end
   end
   // ====
   initial begin
      logic [17:0] b [16];
      logic [1:0] r;
      logic [3:0] c, col;
      logic [7:0] ix;
      int n;
      void'($urandom(32'h78c791bc));
      foreach (mem[i]) mem[i] = 16'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(STATUS_OFS, st(4'h0, MR_CL_RST, MR_BL_RST));
      rd(8'h0c, 32'h0);
      c = 4'($urandom);
      bus(1'b1, TEMP_CTRL_OFS, {30'h0, c[1:0]});
      rd(TEMP_CTRL_OFS, {30'h0, c[1:0]});
      ctl_u.tick(5'h11, 15'h0);
      rd(REFRESH_COUNT_OFS, 32'h1);
      // Refresh only banks 0-1 for about two and a half intervals.
      ctl_u.tick(5'h10, 15'h4001);
      ctl_u.sref(250 * (4 - int'(c[1:0])) - 39);
      ctl_u.tick(5'h10, 15'h4000);
      rd(REFRESH_COUNT_OFS, 32'h3);
      // Every burst length, both latencies, with and without precharge.
      for (int k = 0; k < 4; k++) begin
         n = 2 << k;
         r = 2'($urandom);
         c = 4'($urandom);
         ctl_u.tick(5'h12, 15'h400);
         ctl_u.tick(5'h10, 15'(k + 1 + ((2 + k % 2) << 4) + ((k / 3) << 3)));
         ctl_u.tick(5'h13, {2'(k), 11'h0, r});
         ctl_u.tick(5'h14, {2'(k), 9'h0, c});
         for (int j = 0; j < n; j++) begin
            b[j] = 18'($urandom);
            col = (c & ~4'(n - 1)) |
               (4'(k == 3 ? c ^ j : c + j) & 4'(n - 1));
            ix = {2'(k), r, col};
            mem[ix] = {b[j][17] ? mem[ix][15:8] : b[j][15:8],
               b[j][16] ? mem[ix][7:0] : b[j][7:0]};
            dq_q.push_back(mem[ix]);
         end
         ctl_u.wbeats(n, b);
         ctl_u.tick(5'h15, {2'(k), 2'h0, 1'(k % 2), 6'h0, c});
         repeat (n / 2 + 3) ctl_u.tick(5'h17, 15'h0);
         rd(STATUS_OFS, st(k % 2 ? 4'h0 : 4'h1 << k, 3'(2 + k % 2),
            3'(k + 1)) | 32'(k / 3) << 14);
      end
      // Deep power-down empties the array and closes every bank.
      ctl_u.tick(5'h12, 15'h400);
      ctl_u.tick(5'h06, 15'h0);
      repeat (2) ctl_u.tick(5'h17, 15'h0);
      ctl_u.tick(5'h10, 15'h22);
      rd(STATUS_OFS, st(4'h0, 3'h2, 3'h2));
      ctl_u.tick(5'h13, {2'h3, 11'h0, r});
      repeat (4) dq_q.push_back(16'h0);
      ctl_u.tick(5'h15, {2'h3, 9'h0, c});
      repeat (5) ctl_u.tick(5'h17, 15'h0);
      rd(STATUS_OFS, st(4'h8, 3'h2, 3'h2));
      repeat (4) @(posedge clk);
      check("queued", aq.size() + dq_q.size(), 32'h0);
      test_done;
   end
endmodule : tb_ddr_sdram_access_core
